// *** pkg/crp_pkg.sv ***
/*
  Constants shared by the registered command buffer with parity check.
  Assumes a single system clock; all pins are synchronised inside.
*/
// Operation
// RQ1: With gating enabled and both selects high the block sits in low power and holds the gated outputs.
// RQ2: A fault caught just before low power keeps the fault output low for the whole low-power stay plus two clocks, or until reset.
// RQ3: Parity arrives one clock after its data word and is paired with the word registered one clock earlier.
// RQ4: Once the fault output goes low it stays low for at least two clocks unless reset.
// RQ5: Faults on consecutive cycles keep the fault output low for as long as they persist.
// RQ6: A fault is an odd count of ones over the covered word plus parity, judged only when a select was active, else the old state holds.
// RQ7: Reset clears every register, drives outputs low and the fault output inactive high.
// RQ8: With gating on, data is captured only when a select is low; with gating off, on every clock.
// RQ9: The fault result for a word appears two clocks after the word is registered; the code registers it one clock after the word.
// RQ10: Select, termination and clock-enable outputs register every clock regardless of gating.
package crp_pkg;
  // ---------------------------------------------------------------
  // Widths and timing
  // ---------------------------------------------------------------
  localparam int          DATA_WIDTH   = 22;
  localparam int          PAIR_WIDTH   = 2;
  localparam int          HOLD_CLOCKS  = 2;
  localparam logic [1:0]  HOLD_CNT_W2  = 2'h2;
  localparam logic [1:0]  CNT_ZERO     = 2'h0;
  localparam logic        FAULT_IDLE   = 1'b1;
endpackage

// *** design/crp_sync.sv ***
/*
  Two-flop synchroniser for a vector of pin inputs.
  Assumes the inputs are asynchronous to sys_clk_i.
*/
`timescale 1ns/1ps
module crp_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             sys_clk_i,
  input  wire logic             rst_i,
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] meta;
  logic [WIDTH-1:0] next_meta;
  logic [WIDTH-1:0] next_sync;

  initial begin
    if (WIDTH < 1) $error("crp_sync: WIDTH must be at least 1");
  end

  // Only the second stage ever leaves this module
  always_comb begin
    next_meta = async_i;
    next_sync = meta;
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      meta   <= '0;
      sync_o <= '0;
    end else begin
      meta   <= next_meta;
      sync_o <= next_sync;
    end
  end
endmodule // crp_sync

// *** design/crp_buffer.sv ***
/*
  Registered command buffer with delayed even-parity check.
  Assumes pins are asynchronous to sys_clk_i and pass crp_sync first,
  so every pin sees two extra cycles of latency before capture.
*/
`timescale 1ns/1ps
module crp_buffer
  import crp_pkg::*;
#(
  parameter int DWIDTH = DATA_WIDTH
) (
  input  wire logic              sys_clk_i,
  input  wire logic              rst_i,
  input  wire logic              select_gating_enable_i,
  input  wire logic              chip_select_in_0_i,
  input  wire logic              chip_select_in_1_i,
  input  wire logic [DWIDTH-1:0] command_inputs_i,
  input  wire logic [1:0]        termination_in_i,
  input  wire logic [1:0]        clock_enable_in_i,
  input  wire logic              parity_bit_in_i,
  output logic      [DWIDTH-1:0] registered_outputs_o,
  output logic                   chip_select_out_0_o,
  output logic                   chip_select_out_1_o,
  output logic      [1:0]        termination_out_o,
  output logic      [1:0]        clock_enable_out_o,
  output logic                   parity_fault_n_o,
  output logic                   low_power_state_o
);
  // ---------------------------------------------------------------
  // Pin synchronisation
  // ---------------------------------------------------------------
  localparam int SW = DWIDTH + 8;
  logic [SW-1:0] pin_raw;
  logic [SW-1:0] pin_s;
  logic              gate_s;
  logic              cs0_s;
  logic              cs1_s;
  logic [DWIDTH-1:0] cmd_s;
  logic [1:0]        odt_s;
  logic [1:0]        cke_s;
  logic              par_s;

  initial begin
    if (DWIDTH < 1) $error("crp_buffer: DWIDTH must be at least 1");
  end

  assign pin_raw = {select_gating_enable_i, chip_select_in_0_i,
                    chip_select_in_1_i, command_inputs_i,
                    termination_in_i, clock_enable_in_i, parity_bit_in_i};

  crp_sync #(.WIDTH(SW)) u_sync (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .async_i   (pin_raw),
    .sync_o    (pin_s)
  );

  assign {gate_s, cs0_s, cs1_s, cmd_s, odt_s, cke_s, par_s} = pin_s;

  // Even parity over a word: high means odd number of ones
  function automatic logic odd_ones(input logic [DWIDTH-1:0] w,
                                    input logic p);
    odd_ones = (^w) ^ p;
  endfunction

  // ---------------------------------------------------------------
  // Capture and parity state
  // ---------------------------------------------------------------
  logic              sel_any;
  logic              capture;
  logic              sel_prev;       // Was a select active for the word
  logic              next_sel_prev;
  logic [DWIDTH-1:0] next_q;
  logic [DWIDTH-1:0] word_prev;      // Word waiting for its parity bit
  logic [DWIDTH-1:0] next_word_prev;
  logic              fault_n;
  logic              next_fault_n;
  logic [1:0]        hold_cnt;
  logic [1:0]        next_hold_cnt;
  logic              lp;
  logic              next_lp;
  logic              err_now;

  assign sel_any = ~cs0_s | ~cs1_s;
  assign capture = ~gate_s | sel_any;                        // RQ8
  assign next_lp = gate_s & ~sel_any;                        // RQ1

  // Parity of the previous word against this cycle's parity bit
  assign err_now = odd_ones(word_prev, par_s);               // RQ3

  // Gated data path and the unconditional control path
  always_comb begin
    next_q         = capture ? cmd_s : registered_outputs_o; // RQ1 RQ8
    next_word_prev = cmd_s;                                  // RQ3
    next_sel_prev  = sel_any;
  end

  // Fault latch: low for at least two clocks, stretched by repeated
  // faults, and frozen throughout low power so a fault caught just
  // before low power outlasts it by the two-clock minimum.
  always_comb begin
    next_fault_n  = fault_n;
    next_hold_cnt = hold_cnt;
    if (sel_prev && err_now) begin                           // RQ6 RQ5
      next_fault_n  = ~FAULT_IDLE;
      next_hold_cnt = HOLD_CNT_W2;                           // RQ4
    end else if (lp) begin
      next_hold_cnt = hold_cnt;                              // RQ2
    end else if (hold_cnt > 2'h1) begin
      next_hold_cnt = hold_cnt - 2'h1;
    end else begin
      next_hold_cnt = CNT_ZERO;
      if (!sel_prev) next_fault_n = fault_n;                 // RQ6
      else next_fault_n = FAULT_IDLE;
    end
  end

  // Registers; reset forces outputs low, fault output released
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin                                         // RQ7
      registered_outputs_o <= '0;
      chip_select_out_0_o  <= 1'b0;
      chip_select_out_1_o  <= 1'b0;
      termination_out_o    <= '0;
      clock_enable_out_o   <= '0;
      word_prev            <= '0;
      sel_prev             <= 1'b0;
      fault_n              <= FAULT_IDLE;
      hold_cnt             <= CNT_ZERO;
      lp                   <= 1'b0;
    end else begin
      registered_outputs_o <= next_q;
      chip_select_out_0_o  <= cs0_s;                         // RQ10
      chip_select_out_1_o  <= cs1_s;                         // RQ10
      termination_out_o    <= odt_s;                         // RQ10
      clock_enable_out_o   <= cke_s;                         // RQ10
      word_prev            <= next_word_prev;
      sel_prev             <= next_sel_prev;
      fault_n              <= next_fault_n;                  // RQ9
      hold_cnt             <= next_hold_cnt;
      lp                   <= next_lp;
    end
  end

  assign parity_fault_n_o  = fault_n;
  assign low_power_state_o = lp;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  sequence fault_fall;
    $fell(parity_fault_n_o);
  endsequence

  chk_fault_min_hold: assert property (@(posedge sys_clk_i)
    disable iff (rst_i) fault_fall |=> !parity_fault_n_o) // RQ4
    else $error("fault output released before two clocks");

  chk_fault_when_err: assert property (@(posedge sys_clk_i)
    disable iff (rst_i) (sel_prev && err_now) |=> !parity_fault_n_o) // RQ5
    else $error("parity fault not flagged");

  chk_fault_lp_hold: assert property (@(posedge sys_clk_i)
    disable iff (rst_i) (lp && !parity_fault_n_o) |=> !parity_fault_n_o) // RQ2
    else $error("fault released during low power");

  chk_lp_hold_data: assert property (@(posedge sys_clk_i)
    disable iff (rst_i) (gate_s && cs0_s && cs1_s)
      |=> $stable(registered_outputs_o)) // RQ1
    else $error("gated outputs changed in low power");

  chk_capture_data: assert property (@(posedge sys_clk_i)
    disable iff (rst_i) capture |=> registered_outputs_o == $past(cmd_s)) // RQ8
    else $error("data not captured");

  chk_ctrl_follow: assert property (@(posedge sys_clk_i)
    disable iff (rst_i) 1'b1 |=> (termination_out_o == $past(odt_s)) &&
      (chip_select_out_0_o == $past(cs0_s))) // RQ10
    else $error("control outputs did not follow");

  chk_no_sel_keep: assert property (@(posedge sys_clk_i)
    disable iff (rst_i) (!sel_prev && hold_cnt == CNT_ZERO)
      |=> $stable(parity_fault_n_o)) // RQ6
    else $error("fault state changed without select");

  chk_clean_release: assert property (@(posedge sys_clk_i)
    disable iff (rst_i) (sel_prev && !err_now && !lp && hold_cnt == CNT_ZERO)
      |=> parity_fault_n_o) // RQ9
    else $error("fault not released on clean word");

  chk_reset_state: assert property (@(posedge sys_clk_i)
    rst_i |-> parity_fault_n_o && registered_outputs_o == '0) // RQ7
    else $error("reset state wrong");

  chk_pair_prev: assert property (@(posedge sys_clk_i)
    disable iff (rst_i) 1'b1 |=> word_prev == $past(cmd_s)) // RQ3
    else $error("parity paired with wrong word");
endmodule // crp_buffer

// *** tb/crp_ctrl_model.sv ***
/*
  Controller-side parity source for the command buffer bench.
  Assumes the bench changes the word just after each rising edge.
*/
`timescale 1ns/1ps
module crp_ctrl_model
  import crp_pkg::*;
(
  input  wire logic                  sys_clk_i,
  input  wire logic [DATA_WIDTH-1:0] word_i,
  input  wire logic                  corrupt_i,
  output logic                       parity_o
);
  // Even parity one clock behind its word; corrupt flips it on purpose
  always_ff @(posedge sys_clk_i) begin
    parity_o <= ^word_i ^ corrupt_i;
  end
endmodule // crp_ctrl_model

// *** tb/crp_buffer_test.sv ***
/*
  Self-checking bench for the registered command buffer.
  Assumes crp_pkg, a 25 MHz clock and crp_ctrl_model for parity.
*/
`timescale 1ns/1ps
module crp_buffer_test
  import crp_pkg::*;
;
  logic                  sys_clk_i, rst_i, gate, cs0, cs1, bad, par;
  logic                  qc0, qc1, fn, lp, fl;
  logic [1:0]            odt, cke, odt_q, cke_q;
  logic [DATA_WIDTH-1:0] word, q, qe;
  logic [DATA_WIDTH-1:0] wd [0:1023];
  logic [3:0]            ct [0:1023];
  logic [3:0]            oc [0:1023];
  int                    k, cnt, skip, cyc, mismatches, total_checks;

  crp_buffer crp_buffer_inst (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .select_gating_enable_i(gate),
    .chip_select_in_0_i(cs0), .chip_select_in_1_i(cs1),
    .command_inputs_i(word), .termination_in_i(odt),
    .clock_enable_in_i(cke), .parity_bit_in_i(par),
    .registered_outputs_o(q), .chip_select_out_0_o(qc0),
    .chip_select_out_1_o(qc1), .termination_out_o(odt_q),
    .clock_enable_out_o(cke_q), .parity_fault_n_o(fn),
    .low_power_state_o(lp));
  crp_ctrl_model crp_ctrl_model_inst (.sys_clk_i(sys_clk_i),
    .word_i(word), .corrupt_i(bad), .parity_o(par));

  // -------------------------------------------------------------
  // Reference model
  // -------------------------------------------------------------
  // Pin history is {gating, select 1, select 0, parity}
  function automatic logic act(input logic [3:0] c);
    return !(c[1] & c[2]);
  endfunction

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic results();
    if (mismatches == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Sampled at the falling edge so every output has settled
  always @(negedge sys_clk_i) begin
    k = k + 1;
    wd[k] = word;
    ct[k] = {gate, cs1, cs0, par};
    oc[k] = {odt, cke};
    if (rst_i) begin
      cmp(q, 0);
      cmp(fn, FAULT_IDLE);
      cmp(lp, 0);
      fl = 0;
      cnt = 0;
      skip = 6;
    end else begin
      // Pin latency is three clocks: two sync flops plus the register
      if (act(ct[k-3]) || !ct[k-3][3]) qe = wd[k-3];
      // Fault latch: low power freezes the hold, unjudged words run it
      if (act(ct[k-4])) begin
        if (^wd[k-4] ^ ct[k-3][0]) begin
          fl = 1;
          cnt = 1;
        end else if (cnt != 0) cnt--;
        else fl = 0;
      end else if (!ct[k-4][3] && cnt != 0) cnt--;
      if (skip > 0) skip--;
      else begin
        cmp(q, qe);
        cmp({qc1, qc0, odt_q, cke_q}, {ct[k-3][2:1], oc[k-3]});
        cmp(lp, &ct[k-3][3:1]);
        cmp(fn, !fl);
      end
    end
  end

  // Hang guard: the sequence needs under 850 cycles
  always @(posedge sys_clk_i) begin
    cyc++;
    if (cyc == 2000) begin
      mismatches++;
      results();
    end
  end

  initial begin
    sys_clk_i = 1'h0;
    forever #20 sys_clk_i = ~sys_clk_i;
  end

  task automatic step(input logic g, c0, c1, b);
    @(posedge sys_clk_i);
    word <= DATA_WIDTH'($urandom);
    gate <= g;
    cs0  <= c0;
    cs1  <= c1;
    bad  <= b;
    odt  <= 2'($urandom);
    cke  <= 2'($urandom);
  endtask

  initial begin
    void'($urandom(32'hc1fe));
    {gate, cs0, cs1, bad, odt, cke} = 8'h00;
    word = 22'h00_0000;
    rst_i = 1'h1;
    k = 8;
    skip = 6;
    repeat (2) @(posedge sys_clk_i);
    rst_i <= 1'h0;
    // Random selects and gating, clean parity, low power included
    repeat (400) step(1'($urandom), 1'($urandom), 1'($urandom), 1'h0);
    // Always selected, random faults including consecutive ones
    repeat (400) step(1'($urandom), 1'h0, 1'($urandom),
      1'($urandom % 4 == 0));
    // Fault just before a low-power stay
    repeat (4) step(1'h1, 1'h0, 1'h0, 1'h0);
    step(1'h1, 1'h0, 1'h0, 1'h1);
    repeat (6) step(1'h1, 1'h1, 1'h1, 1'h0);
    repeat (8) step(1'h1, 1'h0, 1'h0, 1'h0);
    // Reset in mid-run with a fault pending
    step(1'h1, 1'h0, 1'h0, 1'h1);
    @(posedge sys_clk_i);
    rst_i <= 1'h1;
    word <= 22'h00_0000;
    {gate, cs0, cs1, bad} <= 4'h0;
    repeat (2) @(posedge sys_clk_i);
    rst_i <= 1'h0;
    repeat (12) step(1'h0, 1'h0, 1'h1, 1'h0);
    results();
  end
endmodule // crp_buffer_test
